// ==== dv/radio_interrupt_controller_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
module radio_interrupt_controller_test;
  import ric_pkg::*;
  typedef struct packed {
    ric_events_type ev;
    logic [7:0]     lo;
    logic [7:0]     hi;
  } ric_row_type;
  logic            clk_sys_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  ric_reg_req_type req       = '0;
  ric_events_type  ev        = '0;
  logic            sleep     = 1'b0;
  logic            stream    = 1'b0;
  logic            fsync     = 1'b0;
  logic [7:0]      rdata, d;
  logic            rvalid, pa, pa_oe, pb, pb_oe, pend, lvl_a, lvl_b;
  int              fail_count = 0;
  int              n_checks   = 0;
  ric_row_type     rows [11];
  logic [7:0]      rst_val [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h1c, 8'h00};
  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;
  ric_top dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .events_i(ev), .sleep_i(sleep),
    .serial_stream_mode_i(stream), .frame_sync_i(fsync), .first_int_pin_o(pa),
    .first_int_pin_oe_o(pa_oe), .second_int_pin_o(pb), .second_int_pin_oe_o(pb_oe),
    .irq_pending_o(pend));
  ric_host_model host_u (.clk_sys_i(clk_sys_i), .pin_a_i(pa), .oe_a_i(pa_oe),
    .pin_b_i(pb), .oe_b_i(pb_oe), .lvl_a_o(lvl_a), .lvl_b_o(lvl_b));
  // register write and read, one request cycle each
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(posedge clk_sys_i) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys_i) req <= '0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    @(posedge clk_sys_i) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i) req <= '0;
    #1 v = rdata;
  endtask
  // one-cycle event, then let pins and flag follow
  task automatic pulse(input ric_events_type e);
    @(posedge clk_sys_i) ev <= e;
    @(posedge clk_sys_i) ev <= '0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: the tests need well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    conclude;
  end
  // main sequence
  initial begin
    rows = '{'{14'h2010, 8'h00, 8'h10}, '{14'h2000, 8'h00, 8'h00}, '{14'h1014, 8'h00, 8'h08},
      '{14'h1010, 8'h00, 8'h00}, '{14'h0810, 8'h00, 8'h04}, '{14'h0408, 8'h00, 8'h02},
      '{14'h0202, 8'h00, 8'h01}, '{14'h0101, 8'h20, 8'h00}, '{14'h0100, 8'h00, 8'h00},
      '{14'h0080, 8'h08, 8'h00}, '{14'h0040, 8'h04, 8'h00}};
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_PIN_A_MASK_LOW + 11'(i), d);
      `CHK(d, rst_val[i])
    end
    rd(11'h3cd, d);
    `CHK(d, 8'h00)
    // spi ready rising after power-on raises chip-ready on both pins
    pulse(14'h0020);
    settle;
    `CHK({lvl_a, lvl_b, pend}, 3'b111)
    rd(ADDR_EVENT_SOURCE_LOW, d);
    `CHK(d, 8'h1e)
    $display("test reset done");
    wr(ADDR_EVENT_SOURCE_LOW, 8'hff);
    wr(ADDR_EVENT_SOURCE_HIGH, 8'hff);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      rd(ADDR_EVENT_SOURCE_LOW, d);
      `CHK(d, rows[i].lo)
      rd(ADDR_EVENT_SOURCE_HIGH, d);
      `CHK(d, rows[i].hi)
      wr(ADDR_EVENT_SOURCE_LOW, 8'hff);
      wr(ADDR_EVENT_SOURCE_HIGH, 8'hff);
    end
    $display("test event rows done");
    // two sources, zero write, single-bit clear, pin a unmasked for the timer
    pulse(14'h00c0);
    wr(ADDR_EVENT_SOURCE_LOW, 8'h00);
    rd(ADDR_EVENT_SOURCE_LOW, d);
    `CHK(d, 8'h0c)
    wr(ADDR_PIN_A_MASK_LOW, 8'h04);
    settle;
    `CHK({lvl_a, lvl_b, pend}, 3'b101)
    wr(ADDR_EVENT_SOURCE_LOW, 8'h04);
    rd(ADDR_EVENT_SOURCE_LOW, d);
    `CHK(d, 8'h08)
    settle;
    `CHK({lvl_a, lvl_b, pend}, 3'b000)
    // high masks gate each pin on its own
    wr(ADDR_PIN_A_MASK_HIGH, 8'h10);
    wr(ADDR_PIN_B_MASK_HIGH, 8'h08);
    pulse(14'h2010);
    settle;
    `CHK({lvl_a, lvl_b, pend}, 3'b101)
    wr(ADDR_EVENT_SOURCE_HIGH, 8'h10);
    settle;
    `CHK({lvl_a, lvl_b, pend}, 3'b000)
    $display("test masks done");
    // stream mode takes the second pin away from the sources
    wr(ADDR_PIN_B_MASK_LOW, 8'h04);
    pulse(14'h0040);
    settle;
    `CHK(lvl_b, 1'b1)
    @(posedge clk_sys_i) stream <= 1'b1;
    settle;
    `CHK(lvl_b, 1'b0)
    @(posedge clk_sys_i) fsync <= 1'b1;
    settle;
    `CHK(lvl_b, 1'b1)
    @(posedge clk_sys_i) stream <= 1'b0;
    wr(ADDR_EVENT_SOURCE_LOW, 8'hff);
    $display("test stream done");
    // sleep releases pins; wake restores masks and chip-ready follows spi ready
    @(posedge clk_sys_i) sleep <= 1'b1;
    settle;
    `CHK({pa_oe, pb_oe}, 2'b00)
    @(posedge clk_sys_i) sleep <= 1'b0;
    settle;
    `CHK({pa_oe, pb_oe}, 2'b11)
    rd(ADDR_PIN_A_MASK_LOW, d);
    `CHK(d, 8'h02)
    pulse(14'h0020);
    rd(ADDR_EVENT_SOURCE_LOW, d);
    `CHK(d, 8'h02)
    settle;
    `CHK({lvl_a, lvl_b}, 2'b11)
    $display("test sleep done");
    conclude;
  end
endmodule

// ==== dv/ric_host_model.sv ====
`timescale 1ns/100ps
// ********
// host inputs: level seen on each line
// ********
module ric_host_model (
  // clock
  input  wire logic clk_sys_i,
  // device pins
  input  wire logic pin_a_i,
  input  wire logic oe_a_i,
  input  wire logic pin_b_i,
  input  wire logic oe_b_i,
  // seen levels
  output logic      lvl_a_o,
  output logic      lvl_b_o
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  // a released line toggles, so it never looks like a stable level
  assign lvl_a_o = oe_a_i ? pin_a_i : ~last_a;
  assign lvl_b_o = oe_b_i ? pin_b_i : ~last_b;
  // remember each line
  always_ff @(posedge clk_sys_i) begin
    last_a <= lvl_a_o;
    last_b <= lvl_b_o;
  end
endmodule

// ==== dv/ric_props.sv ====
`timescale 1ns/100ps
// ********
// port checks
// ********
module ric_props
  import ric_pkg::*;
(
  // clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     sys_rst_i,
  // register access
  input wire ric_pkg::ric_reg_req_type reg_req_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     reg_rvalid_o,
  // power and mode
  input wire logic                     sleep_i,
  input wire logic                     serial_stream_mode_i,
  input wire logic                     frame_sync_i,
  // pins and status
  input wire logic                     first_int_pin_o,
  input wire logic                     first_int_pin_oe_o,
  input wire logic                     second_int_pin_o,
  input wire logic                     second_int_pin_oe_o,
  input wire logic                     irq_pending_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // register port
  property p_rvalid; reg_rvalid_o == $past(reg_req_i.rd); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read strobe wrong");
  property p_hold; !reg_req_i.rd |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmapped; reg_req_i.rd && (reg_req_i.addr < ADDR_PIN_A_MASK_LOW ||
    reg_req_i.addr > ADDR_EVENT_SOURCE_HIGH) |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_res_lo; reg_req_i.rd && reg_req_i.addr == ADDR_EVENT_SOURCE_LOW
    |=> (reg_rdata_o & ~LOW_IMPL_MASK) == 8'h00; endproperty
  a_res_lo: assert property (p_res_lo) else $error("low reserved bits set");
  property p_res_hi; reg_req_i.rd && reg_req_i.addr == ADDR_EVENT_SOURCE_HIGH
    |=> (reg_rdata_o & ~HIGH_IMPL_MASK) == 8'h00; endproperty
  a_res_hi: assert property (p_res_hi) else $error("high reserved bits set");
  // pins
  property p_sleep; sleep_i |=> !first_int_pin_oe_o && !second_int_pin_oe_o; endproperty
  a_sleep: assert property (p_sleep) else $error("pin driven in sleep");
  property p_awake; !sleep_i |=> first_int_pin_oe_o && second_int_pin_oe_o; endproperty
  a_awake: assert property (p_awake) else $error("pin released awake");
  property p_stream; serial_stream_mode_i && !sleep_i
    |=> second_int_pin_o == $past(frame_sync_i); endproperty
  a_stream: assert property (p_stream) else $error("frame sync not on pin");
  property p_pend; (!(sleep_i || serial_stream_mode_i)) [*2]
    |=> irq_pending_o == $past(first_int_pin_o || second_int_pin_o); endproperty
  a_pend: assert property (p_pend) else $error("pending flag wrong");
endmodule
bind ric_top ric_props props_u (
  .clk_sys_i, .sys_rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .sleep_i,
  .serial_stream_mode_i, .frame_sync_i, .first_int_pin_o, .first_int_pin_oe_o,
  .second_int_pin_o, .second_int_pin_oe_o, .irq_pending_o
);

// ==== rtl/ric_pin_drive.sv ====
`timescale 1ns/100ps
// ****************************************
// one interrupt pin: mask, drive, tristate
// ****************************************
module ric_pin_drive #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // sources and masks
  input  wire logic [WIDTH-1:0] pending_i,
  input  wire logic [WIDTH-1:0] enable_i,
  // overrides
  input  wire logic             sleep_i,
  input  wire logic             override_i,
  input  wire logic             override_val_i,
  // pin
  output logic                  pin_o,
  output logic                  pin_oe_o,
  output logic                  active_o
);

  // refuse widths that the reduction cannot serve
  if (WIDTH < 1) begin : g_width_check
    $error("width must be positive");
  end

  logic next_active;

  // any pending source with its enable set
  always_comb begin
    next_active = |(pending_i & enable_i);
  end

  // registered pin level and enable
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
      active_o <= 1'b0;
    end else begin
      active_o <= next_active & ~override_i;
      pin_oe_o <= ~sleep_i;
      if (sleep_i) begin
        pin_o <= 1'b0;
      end else if (override_i) begin
        pin_o <= override_val_i;
      end else begin
        pin_o <= next_active;
      end
    end
  end

endmodule

// ==== rtl/ric_pkg.sv ====
package ric_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [10:0] ADDR_PIN_A_MASK_LOW     = 11'h3c7;
  localparam logic [10:0] ADDR_PIN_A_MASK_HIGH    = 11'h3c8;
  localparam logic [10:0] ADDR_PIN_B_MASK_LOW     = 11'h3c9;
  localparam logic [10:0] ADDR_PIN_B_MASK_HIGH    = 11'h3ca;
  localparam logic [10:0] ADDR_EVENT_SOURCE_LOW   = 11'h3cb;
  localparam logic [10:0] ADDR_EVENT_SOURCE_HIGH  = 11'h3cc;

  // ****************************************
  // low source field positions
  // ****************************************
  localparam int BIT_CHIP_READY       = 1;
  localparam int BIT_TIMER_TIMEOUT    = 2;
  localparam int BIT_CONTROLLER_READY = 3;
  localparam int BIT_POWER_ON_RESET   = 4;
  localparam int BIT_BATTERY_ALERT    = 5;

  // ****************************************
  // high source field positions
  // ****************************************
  localparam int BIT_ASSESS_DONE      = 0;
  localparam int BIT_DELIM_DETECTED   = 1;
  localparam int BIT_DELIM_SENT       = 2;
  localparam int BIT_PACKET_RECEIVED  = 3;
  localparam int BIT_PACKET_SENT      = 4;

  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [7:0] LOW_IMPL_MASK    = 8'h3e;
  localparam logic [7:0] HIGH_IMPL_MASK   = 8'h1f;
  localparam logic [7:0] MASK_LOW_RESET   = 8'h02;
  localparam logic [7:0] MASK_HIGH_RESET  = 8'h00;
  localparam logic [7:0] SRC_LOW_POWERUP  = 8'h1c;
  localparam logic [7:0] SRC_HIGH_RESET   = 8'h00;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic packet_sent;
    logic packet_received;
    logic delim_sent;
    logic delim_detected;
    logic assess_done;
    logic battery_low;
    logic controller_idle_flag;
    logic timer_zero;
    logic spi_ready_flag;
    logic packet_mode;
    logic receive_state;
    logic fcs_valid;
    logic assess_cmd_active;
    logic battery_mon_enabled;
  } ric_events_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [10:0] addr;
    logic [7:0]  wdata;
  } ric_reg_req_type;

endpackage

// ==== rtl/ric_top.sv ====
`timescale 1ns/100ps
module ric_top
  import ric_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     sys_rst_i,
  // register access
  input  wire ric_pkg::ric_reg_req_type reg_req_i,
  output logic [7:0]                    reg_rdata_o,
  output logic                          reg_rvalid_o,
  // event sources
  input  wire ric_pkg::ric_events_type  events_i,
  // power and mode
  input  wire logic                     sleep_i,
  input  wire logic                     serial_stream_mode_i,
  input  wire logic                     frame_sync_i,
  // pins
  output logic                          first_int_pin_o,
  output logic                          first_int_pin_oe_o,
  output logic                          second_int_pin_o,
  output logic                          second_int_pin_oe_o,
  // status word
  output logic                          irq_pending_o
);

  import ric_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] pin_a_mask_low;
  logic [7:0] pin_a_mask_high;
  logic [7:0] pin_b_mask_low;
  logic [7:0] pin_b_mask_high;
  logic [7:0] event_source_low;
  logic [7:0] event_source_high;
  logic       sleep_q;
  logic       ctrl_idle_q;
  logic       spi_ready_q;
  logic       woke_q;
  logic       wake_edge;
  logic [7:0] set_low;
  logic [7:0] set_high;
  logic [7:0] clr_low;
  logic [7:0] clr_high;
  logic       a_active;
  logic       b_active;

  // ****************************************
  // event detection
  // ****************************************

  // previous levels for edge detection and wake tracking
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sleep_q     <= 1'b0;
      ctrl_idle_q <= 1'b0;
      spi_ready_q <= 1'b0;
    end else begin
      sleep_q     <= sleep_i;
      ctrl_idle_q <= events_i.controller_idle_flag;
      spi_ready_q <= events_i.spi_ready_flag;
    end
  end

  assign wake_edge = sleep_q & ~sleep_i;

  // armed by power-on or wake until spi-ready rises
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      woke_q <= 1'b1;
    end else if (wake_edge) begin
      woke_q <= 1'b1;
    end else if (events_i.spi_ready_flag & ~spi_ready_q) begin
      woke_q <= 1'b0;
    end
  end

  // per-bit set requests
  always_comb begin
    set_low  = 8'h00;
    set_high = 8'h00;
    set_high[BIT_PACKET_SENT]     = events_i.packet_sent & events_i.packet_mode;
    set_high[BIT_PACKET_RECEIVED] = events_i.packet_received & events_i.packet_mode
                                    & events_i.fcs_valid;
    set_high[BIT_DELIM_SENT]      = events_i.delim_sent & events_i.packet_mode;
    set_high[BIT_DELIM_DETECTED]  = events_i.delim_detected & events_i.receive_state;
    set_high[BIT_ASSESS_DONE]     = events_i.assess_done & events_i.assess_cmd_active;
    set_low[BIT_BATTERY_ALERT]    = events_i.battery_low & events_i.battery_mon_enabled;
    set_low[BIT_CONTROLLER_READY] = events_i.controller_idle_flag & ~ctrl_idle_q;
    set_low[BIT_TIMER_TIMEOUT]    = events_i.timer_zero;
    set_low[BIT_CHIP_READY]       = woke_q & events_i.spi_ready_flag & ~spi_ready_q;
  end

  // write-one-to-clear requests
  always_comb begin
    clr_low  = 8'h00;
    clr_high = 8'h00;
    if (reg_req_i.wr && reg_req_i.addr == ADDR_EVENT_SOURCE_LOW) begin
      clr_low = reg_req_i.wdata;
    end
    if (reg_req_i.wr && reg_req_i.addr == ADDR_EVENT_SOURCE_HIGH) begin
      clr_high = reg_req_i.wdata;
    end
  end

  // ****************************************
  // source registers
  // ****************************************

  // sticky sources, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      event_source_low  <= SRC_LOW_POWERUP;
      event_source_high <= SRC_HIGH_RESET;
    end else begin
      event_source_low  <= ((event_source_low & ~clr_low) | set_low)
                           & LOW_IMPL_MASK;
      event_source_high <= ((event_source_high & ~clr_high) | set_high)
                           & HIGH_IMPL_MASK;
    end
  end

  // ****************************************
  // mask registers
  // ****************************************

  // masks default on reset and on wake from sleep
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || wake_edge) begin
      pin_a_mask_low  <= MASK_LOW_RESET;
      pin_a_mask_high <= MASK_HIGH_RESET;
      pin_b_mask_low  <= MASK_LOW_RESET;
      pin_b_mask_high <= MASK_HIGH_RESET;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        ADDR_PIN_A_MASK_LOW:  pin_a_mask_low  <= reg_req_i.wdata;
        ADDR_PIN_A_MASK_HIGH: pin_a_mask_high <= reg_req_i.wdata;
        ADDR_PIN_B_MASK_LOW:  pin_b_mask_low  <= reg_req_i.wdata;
        ADDR_PIN_B_MASK_HIGH: pin_b_mask_high <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************

  // one-cycle read answer, unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.addr)
          ADDR_PIN_A_MASK_LOW:    reg_rdata_o <= pin_a_mask_low;
          ADDR_PIN_A_MASK_HIGH:   reg_rdata_o <= pin_a_mask_high;
          ADDR_PIN_B_MASK_LOW:    reg_rdata_o <= pin_b_mask_low;
          ADDR_PIN_B_MASK_HIGH:   reg_rdata_o <= pin_b_mask_high;
          ADDR_EVENT_SOURCE_LOW:  reg_rdata_o <= event_source_low;
          ADDR_EVENT_SOURCE_HIGH: reg_rdata_o <= event_source_high;
          default:                reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // pins
  // ****************************************

  ric_pin_drive #(
    .WIDTH (16)
  ) u_pin_a (
    .clk_sys_i      (clk_sys_i),
    .sys_rst_i      (sys_rst_i),
    .pending_i      ({event_source_high, event_source_low}),
    .enable_i       ({pin_a_mask_high, pin_a_mask_low}),
    .sleep_i        (sleep_i),
    .override_i     (1'b0),
    .override_val_i (1'b0),
    .pin_o          (first_int_pin_o),
    .pin_oe_o       (first_int_pin_oe_o),
    .active_o       (a_active)
  );

  ric_pin_drive #(
    .WIDTH (16)
  ) u_pin_b (
    .clk_sys_i      (clk_sys_i),
    .sys_rst_i      (sys_rst_i),
    .pending_i      ({event_source_high, event_source_low}),
    .enable_i       ({pin_b_mask_high, pin_b_mask_low}),
    .sleep_i        (sleep_i),
    .override_i     (serial_stream_mode_i),
    .override_val_i (frame_sync_i),
    .pin_o          (second_int_pin_o),
    .pin_oe_o       (second_int_pin_oe_o),
    .active_o       (b_active)
  );

  // status word pending flag
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_pending_o <= 1'b0;
    end else begin
      irq_pending_o <= a_active | b_active;
    end
  end

endmodule
